// ===== logic/acrt_config_regs.sv
// Purpose: serial-port register tail of a dual converter channel
// Assumes: serial clock well below clk_i/8, pins async to clk_i
// Notes:   one data byte per frame, later bytes ignored
`timescale 1ns/1ns
`default_nettype none
`include "acrt_defs.svh"

module acrt_config_regs (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	// serial port pins
	input  wire logic                  sclk_i,
	input  wire logic                  csb_n_i,
	input  wire logic                  sdio_i,
	output logic                       sdio_o,
	output logic                       sdio_oe_n_o,
	// signature capture
	input  wire logic                  bist_enable_i,
	input  wire logic                  bist_init_i,
	input  wire logic                  sample_valid_i,
	input  wire logic [7:0]            sample_data_i,
	// analog input control
	output logic                       analog_disconnect_o,
	output logic                       cm_input_enable_o,
	// offset trim
	output logic signed [3:0]          offset_trim_o,
	// output format
	output logic                       output_enable_o,
	output logic                       output_invert_o,
	output acrt_pkg::acrt_format_t     data_format_o,
	output logic                       output_clock_invert_o,
	// reference
	output logic [4:0]                 ref_code_o,
	output logic signed [5:0]          ref_step_o,
	output logic                       ref_external_o,
	output logic                       ref_low_load_o
);
	import acrt_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic                    sclk_m, sclk_s, sclk_d;
	logic                    csb_m, csb_s;
	logic                    sdio_m, sdio_s;
	logic                    sclk_rise, sclk_fall;
	acrt_state_t             state_reg;
	logic [4:0]              cnt_reg;
	logic [15:0]             instr_reg;
	logic [7:0]              data_reg;
	logic [7:0]              rd_shift_reg;
	logic                    rw_reg;
	logic [`ACRT_ADDR_W-1:0] addr_reg;
	logic [15:0]             instr_full;
	logic [`ACRT_ADDR_W-1:0] addr_next;
	logic [7:0]              rd_data;
	logic                    wr_stb;
	logic [7:0]              wr_data;
	logic [3:0]              wr_trim;
	logic                    sdo_reg;
	logic [7:0]              ain_reg, offset_reg, outmode_reg;
	logic [7:0]              phase_reg, ref_reg;
	logic [15:0]             sig;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// the serial pins are async to clk_i; only second and third stages are read
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			csb_m  <= 1'b1;
			csb_s  <= 1'b1;
			sdio_m <= 1'b0;
			sdio_s <= 1'b0;
		end else begin
			sclk_m <= sclk_i;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			csb_m  <= csb_n_i;
			csb_s  <= csb_m;
			sdio_m <= sdio_i;
			sdio_s <= sdio_m;
		end
	end

	// edges of the synchronised serial clock inside a frame
	assign sclk_rise = ~csb_s & sclk_s & ~sclk_d;
	assign sclk_fall = ~csb_s & ~sclk_s & sclk_d;

	// ---------------------------------------------------------------
	// frame decode
	// ---------------------------------------------------------------
	// instruction: read flag, two byte-count bits, 13-bit address
	assign instr_full = {instr_reg[14:0], sdio_s};
	assign addr_next  = instr_full[`ACRT_ADDR_W-1:0];
	assign wr_data    = {data_reg[6:0], sdio_s};
	assign wr_trim    = wr_data[3:0];
	assign wr_stb     = sclk_rise && (state_reg == ST_DATA) && !rw_reg
		&& (cnt_reg == `ACRT_DATA_BITS - 5'd1);

	// ---------------------------------------------------------------
	// frame state machine
	// ---------------------------------------------------------------
	// chip select high aborts any frame; trailing bytes are ignored
	always_ff @(posedge clk_i) begin
		if (reset_i || csb_s) begin
			state_reg <= ST_INSTR;
			cnt_reg   <= 5'd0;
		end else if (sclk_rise) begin
			unique case (state_reg)
				ST_INSTR: begin
					if (cnt_reg == `ACRT_INSTR_BITS - 5'd1) begin
						state_reg <= ST_DATA;
						cnt_reg   <= 5'd0;
					end else begin
						cnt_reg <= cnt_reg + 5'd1;
					end
				end
				ST_DATA: begin
					if (cnt_reg == `ACRT_DATA_BITS - 5'd1) begin
						state_reg <= ST_HOLD;
					end
					cnt_reg <= cnt_reg + 5'd1;
				end
				ST_HOLD: begin
					state_reg <= ST_HOLD;
				end
			endcase
		end
	end

	// shift registers for instruction and write data
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			instr_reg <= 16'h0000;
			data_reg  <= 8'h00;
			rw_reg    <= 1'b0;
			addr_reg  <= '0;
		end else if (sclk_rise && state_reg == ST_INSTR) begin
			instr_reg <= instr_full;
			if (cnt_reg == `ACRT_INSTR_BITS - 5'd1) begin
				rw_reg   <= instr_full[15];
				addr_reg <= addr_next;
			end
		end else if (sclk_rise && state_reg == ST_DATA) begin
			data_reg <= wr_data;
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// unmapped offsets read zero; masks keep reserved bits at zero
	always_comb begin
		unique case (addr_next)
			`ACRT_ADDR_AIN:     rd_data = ain_reg;
			`ACRT_ADDR_OFFSET:  rd_data = offset_reg;
			`ACRT_ADDR_OUTMODE: rd_data = outmode_reg;
			`ACRT_ADDR_PHASE:   rd_data = phase_reg;
			`ACRT_ADDR_REF:     rd_data = ref_reg;
			`ACRT_ADDR_SIG_LO:  rd_data = sig[7:0];
			`ACRT_ADDR_SIG_HI:  rd_data = sig[15:8];
			default:            rd_data = `ACRT_RST_BYTE;
		endcase
	end

	// byte loaded at the last instruction bit, shifted out at falls
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_shift_reg <= 8'h00;
			sdo_reg      <= 1'b0;
		end else if (sclk_rise && state_reg == ST_INSTR
			&& cnt_reg == `ACRT_INSTR_BITS - 5'd1) begin
			rd_shift_reg <= rd_data;
		end else if (sclk_fall && state_reg == ST_DATA && rw_reg) begin
			sdo_reg      <= rd_shift_reg[7];
			rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
		end
	end

	assign sdio_o      = sdo_reg;
	// drive only in the data byte of a read frame
	assign sdio_oe_n_o = !(state_reg == ST_DATA && rw_reg && !csb_s);

	// ---------------------------------------------------------------
	// writable registers
	// ---------------------------------------------------------------
	// signature offsets are read-only, so writes there fall through
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ain_reg     <= `ACRT_RST_BYTE;
			offset_reg  <= `ACRT_RST_BYTE;
			outmode_reg <= `ACRT_RST_BYTE;
			phase_reg   <= `ACRT_RST_BYTE;
			ref_reg     <= `ACRT_RST_BYTE;
		end else if (wr_stb) begin
			unique case (addr_reg)
				`ACRT_ADDR_AIN:     ain_reg <= wr_data & `ACRT_MASK_AIN;
				`ACRT_ADDR_OFFSET:  offset_reg <= wr_data & `ACRT_MASK_OFFSET;
				`ACRT_ADDR_OUTMODE: outmode_reg <= wr_data & `ACRT_MASK_OUTMODE;
				`ACRT_ADDR_PHASE:   phase_reg <= wr_data & `ACRT_MASK_PHASE;
				`ACRT_ADDR_REF:     ref_reg <= wr_data & `ACRT_MASK_REF;
				default:            ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// decoded controls
	// ---------------------------------------------------------------
	// reference step: signed distance from nominal, zero when external
	function automatic logic signed [5:0] ref_step(input logic [4:0] code);
		if (code <= `ACRT_REF_UP_MAX)
			ref_step = $signed({1'b0, code});
		else if (code == `ACRT_REF_EXT)
			ref_step = 6'sh00;
		else
			ref_step = $signed({1'b0, code} - `ACRT_REF_WRAP);
	endfunction

	assign analog_disconnect_o   = ain_reg[`ACRT_BIT_ANA_DISC];
	assign cm_input_enable_o     = ain_reg[`ACRT_BIT_CM_EN];
	assign offset_trim_o         = $signed(offset_reg[3:0]);
	assign output_enable_o       = outmode_reg[`ACRT_BIT_OUT_EN];
	assign output_invert_o       = outmode_reg[`ACRT_BIT_OUT_INV];
	assign data_format_o         = acrt_format_t'(outmode_reg[1:0]);
	assign output_clock_invert_o = phase_reg[`ACRT_BIT_CLK_INV];
	assign ref_code_o            = ref_reg[4:0];
	assign ref_step_o            = ref_step(ref_reg[4:0]);
	assign ref_external_o        = (ref_reg[4:0] == `ACRT_REF_EXT);
	// the external code also lightens the driver load for outside drive
	assign ref_low_load_o        = ref_external_o;

	// ---------------------------------------------------------------
	// signature register
	// ---------------------------------------------------------------
	acrt_signature u_sig (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.init_i   (bist_init_i),
		.enable_i (bist_enable_i),
		.valid_i  (sample_valid_i),
		.data_i   (sample_data_i),
		.sig_o    (sig)
	);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence s_trim_write;
		wr_stb && addr_reg == `ACRT_ADDR_OFFSET;
	endsequence

	property p_trim_write;
		@(posedge clk_i) disable iff (reset_i)
		s_trim_write |=> offset_trim_o == $signed($past(wr_trim));
	endproperty
	a_trim_write: assert property (p_trim_write)
		else $error("offset trim not taken from write");

	property p_sig_lo_reset;
		@(posedge clk_i) reset_i |=> sig[7:0] == 8'h00;
	endproperty
	a_sig_lo_reset: assert property (p_sig_lo_reset)
		else $error("signature low byte not zero after reset");

	property p_sig_hi_reset;
		@(posedge clk_i) reset_i ##1 !reset_i |-> sig[15:8] == 8'h00;
	endproperty
	a_sig_hi_reset: assert property (p_sig_hi_reset)
		else $error("signature high byte not zero after reset");

	property p_ref_reserved;
		@(posedge clk_i) disable iff (reset_i)
		ref_reg[7:5] == 3'h0;
	endproperty
	a_ref_reserved: assert property (p_ref_reserved)
		else $error("reference reserved bits set");

	property p_ref_ext;
		@(posedge clk_i) disable iff (reset_i)
		ref_external_o |-> ref_step_o == 6'sh00 && ref_code_o == 5'h13;
	endproperty
	a_ref_ext: assert property (p_ref_ext)
		else $error("external reference code mismatch");

	property p_ref_down;
		@(posedge clk_i) disable iff (reset_i)
		ref_code_o == 5'h14 |-> ref_step_o == -6'sd12;
	endproperty
	a_ref_down: assert property (p_ref_down)
		else $error("lowest reference step wrong");

	property p_low_load;
		@(posedge clk_i) disable iff (reset_i)
		ref_low_load_o == (ref_code_o == 5'h13);
	endproperty
	a_low_load: assert property (p_low_load)
		else $error("low load setting mismatch");

	property p_outmode_write;
		@(posedge clk_i) disable iff (reset_i)
		wr_stb && addr_reg == `ACRT_ADDR_OUTMODE
		|=> output_enable_o == $past(wr_data[4])
			&& output_invert_o == $past(wr_data[2]);
	endproperty
	a_outmode_write: assert property (p_outmode_write)
		else $error("output mode write not applied");

	property p_idle_release;
		@(posedge clk_i) disable iff (reset_i)
		csb_n_i |-> ##2 sdio_oe_n_o;
	endproperty
	a_idle_release: assert property (p_idle_release)
		else $error("data pin driven outside a frame");

endmodule
`default_nettype wire

// ===== logic/acrt_defs.svh
// Purpose: register offsets, field positions, reset values, constants
// Assumes: 13-bit serial-port register address, 8-bit register data
// Notes:   included by acrt_config_regs, acrt_signature and the bench
`ifndef ACRT_DEFS_SVH
`define ACRT_DEFS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ACRT_ADDR_W          13
`define ACRT_ADDR_AIN        13'h000f
`define ACRT_ADDR_OFFSET     13'h0010
`define ACRT_ADDR_OUTMODE    13'h0014
`define ACRT_ADDR_PHASE      13'h0016
`define ACRT_ADDR_REF        13'h0018
`define ACRT_ADDR_SIG_LO     13'h0024
`define ACRT_ADDR_SIG_HI     13'h0025

// ---------------------------------------------------------------
// writable bit masks, reserved bits read as zero
// ---------------------------------------------------------------
`define ACRT_MASK_AIN        8'h06
`define ACRT_MASK_OFFSET     8'h0f
`define ACRT_MASK_OUTMODE    8'h17
`define ACRT_MASK_PHASE      8'h80
`define ACRT_MASK_REF        8'h1f

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACRT_BIT_ANA_DISC    2
`define ACRT_BIT_CM_EN       1
`define ACRT_BIT_OUT_EN      4
`define ACRT_BIT_OUT_INV     2
`define ACRT_BIT_CLK_INV     7

// ---------------------------------------------------------------
// reset values and reference codes
// ---------------------------------------------------------------
`define ACRT_RST_BYTE        8'h00
`define ACRT_RST_SIG         16'h0000
`define ACRT_REF_UP_MAX      5'h12
`define ACRT_REF_EXT         5'h13
`define ACRT_REF_WRAP        6'h20

// ---------------------------------------------------------------
// serial frame and signature constants
// ---------------------------------------------------------------
`define ACRT_INSTR_BITS      5'd16
`define ACRT_DATA_BITS       5'd8
`define ACRT_SIG_TAPS        16'h8016

`endif

// ===== logic/acrt_pkg.sv
// Purpose: shared types of the configuration register tail
// Assumes: constants live in acrt_defs.svh
// Notes:   one-hot state codes written out
package acrt_pkg;

	// output data format codes
	typedef enum logic [1:0] {
		FMT_OFFSET_BIN = 2'h0,
		FMT_TWOS_COMP  = 2'h1,
		FMT_GRAY       = 2'h2,
		FMT_RESERVED   = 2'h3
	} acrt_format_t;

	// serial frame phases
	typedef enum logic [2:0] {
		ST_INSTR = 3'h1,
		ST_DATA  = 3'h2,
		ST_HOLD  = 3'h4
	} acrt_state_t;

endpackage

// ===== logic/acrt_signature.sv
// Purpose: 16-bit multiple-input signature register for one channel
// Assumes: samples arrive on clk_i with a valid strobe
// Notes:   clears to zero at reset and at init
`timescale 1ns/1ns
`default_nettype none
`include "acrt_defs.svh"

module acrt_signature (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// control
	input  wire logic        init_i,
	input  wire logic        enable_i,
	// sample stream
	input  wire logic        valid_i,
	input  wire logic [7:0]  data_i,
	// signature
	output logic      [15:0] sig_o
);

	logic [15:0] sig_reg;
	logic [15:0] sig_next;
	logic        feedback;

	// ---------------------------------------------------------------
	// compression step
	// ---------------------------------------------------------------
	// feedback from the tap set, sample folded into the low byte
	always_comb begin
		feedback = ^(sig_reg & `ACRT_SIG_TAPS);
		sig_next = {sig_reg[14:0], feedback} ^ {8'h00, data_i};
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	// reset and init both return the signature to zero
	always_ff @(posedge clk_i) begin
		if (reset_i || init_i) begin
			sig_reg <= `ACRT_RST_SIG;
		end else if (enable_i && valid_i) begin
			sig_reg <= sig_next;
		end
	end

	assign sig_o = sig_reg;

endmodule
`default_nettype wire

// ===== dv/acrt_spi_host.sv
// Purpose: serial host model that frames one access per chip-select
// Assumes: pins driven at falling clk_i, sclk idle low between frames
// Notes:   a released data line shows a pattern that flips every cycle
`timescale 1ns/1ns
`default_nettype none

module acrt_spi_host (
	// clock
	input  wire logic clk_i,
	// resolved data wire
	input  wire logic sdio_i,
	// serial pins
	output logic      sclk_o,
	output logic      csb_n_o,
	output logic      sdio_o
);
	logic drv_en;
	logic drv_bit;
	logic filler = 1'b0;

	// port idle at start: select high, clock still
	initial begin
		sclk_o = 1'b0;
		csb_n_o = 1'b1;
		drv_en = 1'b0;
		drv_bit = 1'b0;
	end

	// released line never holds its last value, so no stale bit is read
	always @(posedge clk_i) begin
		filler <= ~filler;
	end
	assign sdio_o = drv_en ? drv_bit : filler;

	// one frame: 16-bit instruction then one byte, msb first
	task automatic xfer(input logic rd, input logic [12:0] a,
		input logic [7:0] d, input int half, input int nb,
		output logic [7:0] q);
		logic [23:0] word;
		word = {rd, 2'b00, a, d};
		q = 8'h00;
		@(negedge clk_i);
		csb_n_o = 1'b0;
		for (int i = 0; i < nb; i++) begin
			drv_en = !(rd && i >= 16);
			drv_bit = word[23 - i];
			repeat (half) @(negedge clk_i);
			if (i >= 16)
				q = {q[6:0], sdio_i};
			sclk_o = 1'b1;
			repeat (half) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		repeat (half) @(negedge clk_i);
		drv_en = 1'b0;
		csb_n_o = 1'b1;
		repeat (6) @(negedge clk_i);
	endtask
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: self-checking bench of the configuration register tail
// Assumes: serial host model drives the pins, inputs change at negedge
// Notes:   shadow copy of the registers gives expected values; unmapped reads expect zero, oe_n expects one
`timescale 1ns/1ns
`default_nettype none
`include "acrt_defs.svh"
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
	$time, (got), (exp)); end end

module tb_top;
	import acrt_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk, reset, sclk, csb_n, host_sdio, sdio_w, dut_sdio, oe_n;
	logic bist_en, bist_init, s_valid, ana_disc, cm_en, out_en, out_inv;
	logic clk_inv, ref_ext, ref_low;
	logic [7:0] s_data;
	logic signed [3:0] off_trim;
	logic [4:0] ref_code;
	logic signed [5:0] ref_step;
	acrt_format_t fmt;
	int mismatches = 0;
	int checks_done = 0;
	logic [7:0] rnd = 8'h48;
	logic [7:0] sh [0:63];
	logic [15:0] sig_exp;
	localparam logic [12:0] REGS [0:6] = '{`ACRT_ADDR_AIN,
		`ACRT_ADDR_OFFSET, `ACRT_ADDR_OUTMODE, `ACRT_ADDR_PHASE,
		`ACRT_ADDR_REF, `ACRT_ADDR_SIG_LO, `ACRT_ADDR_SIG_HI};

	// device drives the wire only while its enable is low
	assign sdio_w = oe_n ? host_sdio : dut_sdio;

	acrt_spi_host i_host (.clk_i(clk), .sdio_i(sdio_w), .sclk_o(sclk),
		.csb_n_o(csb_n), .sdio_o(host_sdio));

	acrt_config_regs i_dut (.clk_i(clk), .reset_i(reset), .sclk_i(sclk),
		.csb_n_i(csb_n), .sdio_i(sdio_w), .sdio_o(dut_sdio),
		.sdio_oe_n_o(oe_n), .bist_enable_i(bist_en),
		.bist_init_i(bist_init), .sample_valid_i(s_valid),
		.sample_data_i(s_data), .analog_disconnect_o(ana_disc),
		.cm_input_enable_o(cm_en), .offset_trim_o(off_trim),
		.output_enable_o(out_en), .output_invert_o(out_inv),
		.data_format_o(fmt), .output_clock_invert_o(clk_inv),
		.ref_code_o(ref_code), .ref_step_o(ref_step),
		.ref_external_o(ref_ext), .ref_low_load_o(ref_low));

	// clock of 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [7:0] mask_of(input logic [12:0] a);
		case (a)
			`ACRT_ADDR_AIN:     return `ACRT_MASK_AIN;
			`ACRT_ADDR_OFFSET:  return `ACRT_MASK_OFFSET;
			`ACRT_ADDR_OUTMODE: return `ACRT_MASK_OUTMODE;
			`ACRT_ADDR_PHASE:   return `ACRT_MASK_PHASE;
			`ACRT_ADDR_REF:     return `ACRT_MASK_REF;
			default:            return 8'h00;
		endcase
	endfunction

	// up codes step positive, down codes wrap negative, external is zero
	function automatic logic [5:0] exp_step(input logic [4:0] c);
		if (c == 5'h13)
			return 6'h00;
		else if (c > 5'h12)
			return {1'b0, c} - 6'h20;
		return {1'b0, c};
	endfunction

	// random sclk half period of 5 to 8 clocks, both fast and slow
	task automatic xfer(input logic rd, input logic [12:0] a,
		input logic [7:0] d, input int nb, output logic [7:0] q);
		rnd = lfsr(rnd);
		i_host.xfer(rd, a, d, 5 + int'(rnd[1:0]), nb, q);
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b0, a, d, 24, q);
		if (mask_of(a) != 8'h00)
			sh[a[5:0]] = d & mask_of(a);
	endtask

	task automatic rd_chk(input logic [12:0] a);
		logic [7:0] q;
		xfer(1'b1, a, 8'h00, 24, q);
		`CHECK(q, sh[a[5:0]])
	endtask

	task automatic check_outputs();
		`CHECK(ana_disc, sh[6'h0f][2])
		`CHECK(cm_en, sh[6'h0f][1])
		`CHECK(off_trim, sh[6'h10][3:0])
		`CHECK(({out_en, out_inv, fmt}), ({sh[6'h14][4], sh[6'h14][2:0]}))
		`CHECK(clk_inv, sh[6'h16][7])
		`CHECK(ref_code, sh[6'h18][4:0])
		`CHECK(ref_step, exp_step(sh[6'h18][4:0]))
		`CHECK(ref_ext, sh[6'h18][4:0] == 5'h13)
		`CHECK(ref_low, sh[6'h18][4:0] == 5'h13)
		`CHECK(oe_n, 1'b1)
	endtask

	task automatic finish_test();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// watchdog cuts a hung run short
	initial begin
		repeat (95000) @(posedge clk);
		mismatches++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] q;
		reset = 1'b1;
		bist_en = 1'b0;
		bist_init = 1'b0;
		s_valid = 1'b0;
		s_data = 8'h00;
		for (int i = 0; i < 64; i++)
			sh[i] = 8'h00;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		check_outputs();
		foreach (REGS[k])
			rd_chk(REGS[k]);
		$display("test reset done");
		// every code of reference, trim and format, random upper bits
		for (int i = 0; i < 32; i++) begin
			rnd = lfsr(rnd);
			wr(`ACRT_ADDR_REF, {rnd[7:5], i[4:0]});
			if (i < 16)
				wr(`ACRT_ADDR_OFFSET, {rnd[7:4], i[3:0]});
			if (i < 8)
				wr(`ACRT_ADDR_OUTMODE, {rnd[7:5], i[2], rnd[3], ~i[2], i[1:0]});
			check_outputs();
			rd_chk(`ACRT_ADDR_REF);
		end
		$display("test codes done");
		repeat (4) begin
			foreach (REGS[k]) begin
				rnd = lfsr(rnd);
				wr(REGS[k], rnd);
				rd_chk(REGS[k]);
			end
			check_outputs();
		end
		$display("test random done");
		// signature folds valid samples only, then freezes
		bist_init = 1'b1;
		repeat (2) @(negedge clk);
		bist_init = 1'b0;
		bist_en = 1'b1;
		sig_exp = 16'h0000;
		repeat (40) begin
			rnd = lfsr(rnd);
			s_valid = rnd[0];
			s_data = lfsr(rnd);
			@(negedge clk);
			if (s_valid)
				sig_exp = {sig_exp[14:0], ^(sig_exp & `ACRT_SIG_TAPS)}
					^ {8'h00, s_data};
		end
		s_valid = 1'b0;
		bist_en = 1'b0;
		sh[6'h24] = sig_exp[7:0];
		sh[6'h25] = sig_exp[15:8];
		wr(`ACRT_ADDR_SIG_LO, ~sig_exp[7:0]);
		wr(`ACRT_ADDR_SIG_HI, ~sig_exp[15:8]);
		rd_chk(`ACRT_ADDR_SIG_LO);
		rd_chk(`ACRT_ADDR_SIG_HI);
		$display("test signature done");
		// unmapped places and an aborted write change nothing
		for (int k = 0; k < 3; k++) begin
			logic [12:0] a;
			a = (k == 0) ? 13'h0011 : (k == 1) ? 13'h1024 : 13'h0118;
			wr(a, 8'hff);
			xfer(1'b1, a, 8'h00, 24, q);
			`CHECK(q, 8'h00)
		end
		xfer(1'b0, `ACRT_ADDR_OFFSET, ~sh[6'h10], 20, q);
		check_outputs();
		$display("test refusal done");
		finish_test();
	end
endmodule

`default_nettype wire
